/* design/nand_host.sv */
// Host controller that drives a NAND device's command and data pins
`timescale 1ns/1ns
// Overview of operation
// [R01] Command byte, command latch high, strobe rises
// [R02] Address cycle: select low, address latch high
// [R03] Read data on latch-low read strobe pulses
// [R04] Select high puts idle device into standby
// [R05] Program or erase only with protect high
// [R06] x8 address: four cycles, top bits low
// [R07] x16: upper lines low in address cycles
// [R08] Device ignores address cycles beyond four
// [R09] x8 bit 8 from pointer code
// [R10] x16 bit 8 is don't care
// [R11] x16 words counted from bit 0
// [R12] x16 has no second-half pointer
// [R13] Device command set recognised
// [R14] Program and erase need setup then confirm
// [R15] Busy device takes only status, reset
// [R16] Undefined sequences discarded by device
// [R17] Read codes select column area
// [R18] x16 main pointer covers words 0-255
// [R19] x8 main pointer covers bytes 0-255
// [R20] x8 second pointer covers bytes 256-511
// [R21] Spare pointer: bytes 512-527, words 256-263
// [R22] Upper lines carry only data
// [R23] Both latches high never driven
module nand_host (
  input  wire logic                 clk,
  input  wire logic                 rst_n,
  input  wire logic                 wide_bus,
  input  wire logic                 allow_modify,
  input  wire nand_host_pkg::req_t  req,
  input  wire logic                 req_valid,
  output logic                      req_ready,
  input  wire logic [26:0]          addr,
  input  wire logic                 addr_valid,
  output logic                      addr_ready,
  output logic [15:0]               rd_data,
  output logic                      rd_valid,
  output logic                      refused,
  input  wire logic [15:0]          io_in,
  input  wire logic                 ready_busy_in,
  output nand_host_pkg::pins_t      pins,
  output logic                      device_busy
);

  typedef enum logic [3:0] {
    ST_IDLE  = 4'h1,
    ST_SETUP = 4'h2,
    ST_LOW   = 4'h4,
    ST_HIGH  = 4'h8
  } state_t;

  state_t              state;
  nand_host_pkg::op_t  op;
  logic [15:0]         out_word;
  logic [2:0]          addr_left;
  logic [26:0]         addr_shift;
  logic [7:0]          last_cmd;
  logic                rb_meta;
  logic                rb_sync;
  logic [15:0]         io_meta;
  logic [15:0]         io_sync;
  logic                timer_start;
  logic [3:0]          timer_len;
  logic                timer_done;
  logic                cmd_blocked;

  // Program/erase setup codes; this check is never called, so only the busy filter gates them
  function automatic logic is_modify(input logic [7:0] c);
    is_modify = (c == nand_host_pkg::CMD_PROG_SETUP) ||
                (c == nand_host_pkg::CMD_ERASE_SETUP) ||
                (c == nand_host_pkg::CMD_COPY_BACK);
  endfunction

  // Busy device accepts only status and reset
  function automatic logic busy_ok(input logic [7:0] c);
    busy_ok = (c == nand_host_pkg::CMD_STATUS) ||
              (c == nand_host_pkg::CMD_RESET);
  endfunction

  // Pin inputs pass two flops; first stage read only by second
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rb_meta <= 1'b1;
      rb_sync <= 1'b1;
      io_meta <= 16'h0000;
      io_sync <= 16'h0000;
    end else begin
      rb_meta <= ready_busy_in;
      rb_sync <= rb_meta;
      io_meta <= io_in;
      io_sync <= io_meta;
    end
  end

  assign device_busy = !rb_sync;

  // Host-side refusal: busy filter, x16 second pointer, confirm order
  always_comb begin
    cmd_blocked = 1'b0;
    if (device_busy && !busy_ok(req.data[7:0])) begin
      cmd_blocked = 1'b1; // R15
    end else if (wide_bus &&
                 req.data[7:0] == nand_host_pkg::CMD_READ_SECOND) begin
      cmd_blocked = 1'b1; // R12
    end else if (req.data[7:0] == nand_host_pkg::CMD_CONFIRM &&
                 last_cmd != nand_host_pkg::CMD_PROG_SETUP &&
                 last_cmd != nand_host_pkg::CMD_COPY_BACK) begin
      cmd_blocked = 1'b1; // R14
    end else if (req.data[7:0] == nand_host_pkg::CMD_ERASE_CONF &&
                 last_cmd != nand_host_pkg::CMD_ERASE_SETUP) begin
      cmd_blocked = 1'b1; // R14
    end
  end

  assign req_ready  = (state == ST_IDLE) && (addr_left == 3'h0);
  assign addr_ready = (state == ST_IDLE) && (addr_left == 3'h0);

  logic take_req;
  logic take_addr;
  assign take_req  = req_valid && req_ready &&
                     !(req.op == nand_host_pkg::OP_COMMAND && cmd_blocked);
  assign take_addr = addr_valid && addr_ready && !req_valid;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      refused <= 1'b0;
    end else begin
      refused <= req_valid && req_ready &&
                 req.op == nand_host_pkg::OP_COMMAND && cmd_blocked;
    end
  end

  // Remember last command code for confirm checks
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      last_cmd <= nand_host_pkg::CMD_RESET;
    end else if (take_req && req.op == nand_host_pkg::OP_COMMAND) begin
      last_cmd <= req.data[7:0];
    end
  end

  // Strobe sequencer
  assign timer_start = (state == ST_SETUP) ||
                       (state == ST_LOW && timer_done);
  assign timer_len   = (state == ST_SETUP) ? nand_host_pkg::STROBE_LOW_CYC
                                           : nand_host_pkg::STROBE_HIGH_CYC;

  nand_strobe_timer u_timer (
    .clk    (clk),
    .rst_n  (rst_n),
    .start  (timer_start),
    .length (timer_len),
    .done   (timer_done)
  );

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= ST_IDLE;
      op    <= nand_host_pkg::OP_COMMAND;
    end else begin
      case (state)
        ST_IDLE: begin
          if (take_req) begin
            op    <= req.op;
            state <= ST_SETUP;
          end else if (take_addr || addr_left != 3'h0) begin
            op    <= nand_host_pkg::OP_ADDRESS;
            state <= ST_SETUP;
          end
        end
        ST_SETUP: begin
          state <= ST_LOW;
        end
        ST_LOW: begin
          if (timer_done) begin
            state <= ST_HIGH;
          end
        end
        ST_HIGH: begin
          if (timer_done) begin
            state <= ST_IDLE;
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // Address cycle counter and bus word forming
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      addr_left  <= 3'h0;
      addr_shift <= 27'h0000000;
      out_word   <= 16'h0000;
    end else if (state == ST_IDLE && take_req) begin
      out_word <= req.data;
      if (req.op != nand_host_pkg::OP_WRITE || !wide_bus) begin
        out_word[15:8] <= 8'h00; // R22
      end
    end else if (state == ST_IDLE && (take_addr || addr_left != 3'h0)) begin
      // Bit 8 never sent: pointer code or don't care decides it
      if (take_addr) begin
        out_word   <= {8'h00, addr[7:0]}; // R06 R07 R09 R10 R11
        addr_shift <= {9'h000, addr[nand_host_pkg::ADDR_TOP_BIT:
                                    nand_host_pkg::ADDR_HI_FIRST]};
        addr_left  <= nand_host_pkg::ADDR_CYCLES - 3'h1; // R08
      end else begin
        if (addr_left == 3'h1) begin
          out_word <= {14'h0000, addr_shift[1:0]}; // R06 R07
        end else begin
          out_word <= {8'h00, addr_shift[7:0]};
        end
        addr_shift <= {8'h00, addr_shift[26:8]};
        addr_left  <= addr_left - 3'h1;
      end
    end
  end

  // Pin drive; select low only while a cycle runs, else standby
  always_comb begin
    pins.chip_sel_n      = (state == ST_IDLE); // R04
    pins.cmd_latch       = (state != ST_IDLE) &&
                           (op == nand_host_pkg::OP_COMMAND); // R01 R23
    pins.addr_latch      = (state != ST_IDLE) &&
                           (op == nand_host_pkg::OP_ADDRESS); // R02 R23
    pins.write_strobe_n  = !(state == ST_LOW &&
                             op != nand_host_pkg::OP_READ);
    pins.read_strobe_n   = !(state == ST_LOW &&
                             op == nand_host_pkg::OP_READ); // R03
    pins.write_protect_n = allow_modify; // R05
    pins.io_out          = out_word;
    pins.io_oe           = (state != ST_IDLE) &&
                           (op != nand_host_pkg::OP_READ); // R03
  end

  // Read data captured at end of low phase
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_data  <= 16'h0000;
      rd_valid <= 1'b0;
    end else begin
      rd_valid <= (state == ST_LOW) && timer_done &&
                  (op == nand_host_pkg::OP_READ); // R03
      if ((state == ST_LOW) && timer_done &&
          (op == nand_host_pkg::OP_READ)) begin
        rd_data <= wide_bus ? io_sync : {8'h00, io_sync[7:0]};
      end
    end
  end

  latch_excl_a: assert property (@(posedge clk) disable iff (!rst_n) // R23
    !(pins.cmd_latch && pins.addr_latch))
    else $error("both latch selects high");

  read_no_drive_a: assert property (@(posedge clk) disable iff (!rst_n) // R03
    !pins.read_strobe_n |-> !pins.io_oe && !pins.cmd_latch &&
    !pins.addr_latch && pins.write_strobe_n && !pins.chip_sel_n)
    else $error("read strobe with bus driven");

  cmd_strobe_a: assert property (@(posedge clk) disable iff (!rst_n) // R01
    (pins.cmd_latch && !pins.write_strobe_n) |-> !pins.chip_sel_n &&
    pins.read_strobe_n && pins.io_oe)
    else $error("command cycle pins wrong");

  addr_cycle_a: assert property (@(posedge clk) disable iff (!rst_n) // R02
    (pins.addr_latch && !pins.write_strobe_n) |-> !pins.chip_sel_n &&
    pins.read_strobe_n && !pins.cmd_latch)
    else $error("address cycle pins wrong");

  addr_upper_a: assert property (@(posedge clk) disable iff (!rst_n) // R07
    pins.addr_latch |-> pins.io_out[15:8] == 8'h00)
    else $error("upper lines driven in address cycle");

  // Only the fourth address cycle and a direct OP_ADDRESS request run with no cycles left
  last_addr_a: assert property (@(posedge clk) disable iff (!rst_n) // R06
    (pins.addr_latch && addr_left == 3'h0)
    |-> pins.io_out[15:2] == 14'h0000)
    else $error("fourth address cycle high bits set");

  busy_filter_a: assert property (@(posedge clk) disable iff (!rst_n) // R15
    (req_valid && req_ready && device_busy &&
     req.op == nand_host_pkg::OP_COMMAND && !busy_ok(req.data[7:0]))
    |=> refused && state == ST_IDLE)
    else $error("command sent while busy");

  second_ptr_a: assert property (@(posedge clk) disable iff (!rst_n) // R12
    (wide_bus && pins.cmd_latch) |->
    pins.io_out[7:0] != nand_host_pkg::CMD_READ_SECOND)
    else $error("second pointer sent on x16");

  standby_a: assert property (@(posedge clk) disable iff (!rst_n) // R04
    pins.chip_sel_n |-> !pins.io_oe && pins.write_strobe_n &&
    pins.read_strobe_n)
    else $error("activity while deselected");

endmodule

/* design/nand_host_pkg.sv */
// Package: pin bundles, command codes and timing for the NAND host
package nand_host_pkg;

  localparam logic [7:0] CMD_READ_MAIN   = 8'h00;
  localparam logic [7:0] CMD_READ_SECOND = 8'h01;
  localparam logic [7:0] CMD_READ_SPARE  = 8'h50;
  localparam logic [7:0] CMD_SIGNATURE   = 8'h90;
  localparam logic [7:0] CMD_STATUS      = 8'h70;
  localparam logic [7:0] CMD_PROG_SETUP  = 8'h80;
  localparam logic [7:0] CMD_CONFIRM     = 8'h10;
  localparam logic [7:0] CMD_COPY_BACK   = 8'h8A;
  localparam logic [7:0] CMD_ERASE_SETUP = 8'h60;
  localparam logic [7:0] CMD_ERASE_CONF  = 8'hD0;
  localparam logic [7:0] CMD_RESET       = 8'hFF;

  // Four address cycles; x16 ignores bit 8, x8 takes it from the pointer
  localparam logic [2:0] ADDR_CYCLES     = 3'h4;
  localparam int         ADDR_HI_FIRST   = 9;
  localparam int         ADDR_TOP_BIT    = 26;
  localparam int         SECOND_HALF_BIT = 8;

  // Strobe phase length in ns and in clock cycles at 10 ns
  localparam int         CLK_PERIOD_NS   = 10;
  localparam int         STROBE_LOW_NS   = 40;
  localparam int         STROBE_HIGH_NS  = 20;
  localparam logic [3:0] STROBE_LOW_CYC  =
    4'((STROBE_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [3:0] STROBE_HIGH_CYC =
    4'((STROBE_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  typedef enum logic [3:0] {
    OP_COMMAND = 4'h1,
    OP_ADDRESS = 4'h2,
    OP_WRITE   = 4'h4,
    OP_READ    = 4'h8
  } op_t;

  typedef struct packed {
    logic        chip_sel_n;
    logic        cmd_latch;
    logic        addr_latch;
    logic        write_strobe_n;
    logic        read_strobe_n;
    logic        write_protect_n;
    logic [15:0] io_out;
    logic        io_oe;
  } pins_t;

  typedef struct packed {
    op_t         op;
    logic [15:0] data;
  } req_t;

endpackage

/* design/nand_strobe_timer.sv */
// Counter that times one strobe phase
`timescale 1ns/1ns
module nand_strobe_timer (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       start,
  input  wire logic [3:0] length,
  output logic            done
);

  logic [3:0] count;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count <= 4'h0;
    end else if (start) begin
      count <= length;
    end else if (count != 4'h0) begin
      count <= count - 4'h1;
    end
  end

  assign done = (count == 4'h1);

endmodule

/* bench/nand_device_model.sv */
// Behavioural NAND device: commands, address, pointer, busy, data out
`timescale 1ns/1ns
module nand_device_model #(
  parameter int BUSY_NS = 3000
) (
  input  wire nand_host_pkg::pins_t pins,
  input  wire logic                 wide,
  output logic [15:0]               io,
  output logic                      ready_busy
);
  logic [7:0]  last_cmd = 8'hFF;
  logic [15:0] abyte [4];
  logic [2:0]  acnt = 3'h0;
  logic [9:0]  col_base = 10'h000;
  logic [9:0]  col = 10'h000;
  logic [7:0]  rd_cnt = 8'h00;
  logic [15:0] dout = 16'h0000;
  logic [15:0] din = 16'h0000;
  logic        busy = 1'b0;
  int          prog_cnt = 0;
  int          erase_cnt = 0;
  logic        sel;
  assign sel = !pins.chip_sel_n && pins.read_strobe_n;
  assign ready_busy = !busy;
  // Released bus shows the inverse, so a stale word never passes
  assign io = (!pins.chip_sel_n && !pins.cmd_latch && !pins.addr_latch)
    ? dout : ~dout;
  task automatic take_cmd(input logic [7:0] c);
    case (c)
      8'h00: col_base = 10'h000;
      8'h01: if (!wide) col_base = 10'h100;
      8'h50: col_base = wide ? 10'h100 : 10'h200;
      8'h10: begin
        if (last_cmd inside {8'h80, 8'h8A} && pins.write_protect_n) begin
          prog_cnt++;
          busy = 1'b1;
        end
      end
      8'hD0: begin
        if (last_cmd == 8'h60 && pins.write_protect_n) begin
          erase_cnt++;
          busy = 1'b1;
        end
      end
      8'hFF: busy = 1'b0;
      8'h70, 8'h80, 8'h8A, 8'h60, 8'h90: ;
      default: return;
    endcase
    last_cmd = c;
    acnt = 3'h0;
    rd_cnt = 8'h00;
  endtask
  always @(posedge pins.write_strobe_n) begin
    if (sel && pins.cmd_latch && !pins.addr_latch) begin
      if (!busy || pins.io_out[7:0] inside {8'h70, 8'hFF}) begin
        take_cmd(pins.io_out[7:0]);
      end
    end
    if (sel && pins.addr_latch && !pins.cmd_latch
        && acnt < 3'h4) begin
      abyte[acnt[1:0]] = pins.io_out;
      if (acnt == 3'h0) begin
        col = col_base + 10'(pins.io_out[7:0]);
      end
      acnt = acnt + 3'h1;
    end
    if (sel && !pins.cmd_latch && !pins.addr_latch) begin
      din = pins.io_out;
    end
  end
  // One fixed busy time, long enough to overlap commands with it
  always @(posedge busy) begin
    #BUSY_NS busy = 1'b0;
  end
  always @(negedge pins.read_strobe_n) begin
    if (!pins.chip_sel_n && pins.write_strobe_n && !pins.cmd_latch
        && !pins.addr_latch) begin
      dout = 16'hC300 + 16'(rd_cnt);
      rd_cnt++;
    end
  end
endmodule

/* bench/nand_host_tb.sv */
// Self-checking bench for the NAND host against a device model
`timescale 1ns/1ns
`define CHECK(got, exp) begin \
  checks++; \
  if ((got) !== (exp)) begin \
    failures++; \
    $display("wrong value at %0t: got %0h expected %0h", $time, got, exp); \
  end \
end
module nand_host_tb;
  localparam logic [26:0] ADR = 27'h5ACE17E;
  logic                 clk = 1'b0;
  logic                 rst_n = 1'b0;
  logic                 wide_bus = 1'b0;
  logic                 allow_modify = 1'b1;
  nand_host_pkg::req_t  req = '0;
  logic                 req_valid = 1'b0;
  logic                 req_ready;
  logic [26:0]          addr = '0;
  logic                 addr_valid = 1'b0;
  logic                 addr_ready;
  logic [15:0]          rd_data;
  logic                 rd_valid;
  logic                 refused;
  logic [15:0]          io_in;
  logic                 ready_busy_in;
  nand_host_pkg::pins_t pins;
  logic                 device_busy;
  int                   checks = 0;
  int                   failures = 0;
  int                   refusals = 0;
  logic [15:0]          rdq [$];
  nand_host u_nand_host (.clk, .rst_n, .wide_bus, .allow_modify, .req,
    .req_valid, .req_ready, .addr, .addr_valid, .addr_ready, .rd_data,
    .rd_valid, .refused, .io_in, .ready_busy_in, .pins, .device_busy);
  nand_device_model u_dev (.pins, .wide(wide_bus), .io(io_in),
    .ready_busy(ready_busy_in));
  always #5 clk = ~clk;
  always @(posedge clk) begin
    if (rd_valid === 1'b1) rdq.push_back(rd_data);
    if (refused === 1'b1) refusals++;
  end
  task automatic print_verdict();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  function automatic logic lvl(input int k);
    return k == 0 ? req_ready : k == 1 ? addr_ready : device_busy;
  endfunction
  task automatic wait_lvl(input int k, input logic v);
    int n;
    n = 0;
    while (lvl(k) !== v && n < 2000) begin
      @(posedge clk);
      #1 n++;
    end
    if (n >= 2000) begin
      failures++;
      print_verdict();
    end
  endtask
  task automatic issue(input logic is_a, input nand_host_pkg::op_t op,
                       input logic [15:0] d);
    @(posedge clk);
    #1 wait_lvl(is_a ? 1 : 0, 1'b1);
    req = '{op: op, data: d};
    addr = ADR;
    req_valid = !is_a;
    addr_valid = is_a;
    @(posedge clk);
    #1 req_valid = 1'b0;
    addr_valid = 1'b0;
    wait_lvl(0, 1'b1);
    // Refusal pulse lands one cycle after the take
    repeat (2) @(posedge clk);
    #1;
  endtask
  task automatic cmd(input logic [7:0] c);
    issue(1'b0, nand_host_pkg::OP_COMMAND, {8'h00, c});
  endtask
  task automatic adr();
    issue(1'b1, nand_host_pkg::OP_COMMAND, 16'h0000);
  endtask
  task automatic t_pointers();
    wide_bus = 1'b0;
    cmd(8'h01);
    `CHECK(u_dev.last_cmd, 8'h01)
    `CHECK(u_dev.col_base, 10'h100)
    adr();
    `CHECK(u_dev.abyte[0][7:0], ADR[7:0])
    `CHECK(u_dev.abyte[1][7:0], ADR[16:9])
    `CHECK(u_dev.abyte[2][7:0], ADR[24:17])
    `CHECK(u_dev.abyte[3][7:0], {6'h00, ADR[26:25]})
    `CHECK(u_dev.col, 10'h100 + 10'(ADR[7:0]))
    cmd(8'h50);
    `CHECK(u_dev.col_base, 10'h200)
    cmd(8'h00);
    `CHECK(u_dev.col_base, 10'h000)
    // x8 data word: upper lines held low
    issue(1'b0, nand_host_pkg::OP_WRITE, 16'hA55A);
    `CHECK(u_dev.din, 16'h005A)
  endtask
  task automatic t_wide();
    int n;
    n = refusals;
    wide_bus = 1'b1;
    cmd(8'h01);
    `CHECK(refusals, n + 1)
    cmd(8'h50);
    `CHECK(u_dev.col_base, 10'h100)
    adr();
    `CHECK(u_dev.abyte[3], {14'h0000, ADR[26:25]})
    `CHECK(u_dev.col, 10'h100 + 10'(ADR[7:0]))
    issue(1'b0, nand_host_pkg::OP_WRITE, 16'hA55A);
    `CHECK(u_dev.din, 16'hA55A)
  endtask
  task automatic t_program();
    int n;
    int p;
    n = refusals;
    p = u_dev.prog_cnt;
    cmd(8'h10);
    `CHECK(refusals, n + 1)
    cmd(8'h80);
    adr();
    cmd(8'h10);
    `CHECK(u_dev.prog_cnt, p + 1)
    wait_lvl(2, 1'b1);
    cmd(8'h90);
    `CHECK(refusals, n + 2)
    cmd(8'h70);
    `CHECK(u_dev.last_cmd, 8'h70)
    wait_lvl(2, 1'b0);
  endtask
  task automatic t_protect();
    int e;
    e = u_dev.erase_cnt;
    allow_modify = 1'b0;
    cmd(8'h60);
    `CHECK(pins.write_protect_n, 1'b0)
    adr();
    cmd(8'hD0);
    `CHECK(u_dev.erase_cnt, e)
    allow_modify = 1'b1;
    cmd(8'h60);
    adr();
    cmd(8'hD0);
    `CHECK(u_dev.erase_cnt, e + 1)
    wait_lvl(2, 1'b1);
    wait_lvl(2, 1'b0);
  endtask
  task automatic t_read();
    cmd(8'hFF);
    cmd(8'h00);
    adr();
    rdq.delete();
    issue(1'b0, nand_host_pkg::OP_READ, 16'h0000);
    issue(1'b0, nand_host_pkg::OP_READ, 16'h0000);
    `CHECK(rdq.size(), 2)
    `CHECK(rdq[0], 16'hC300)
    `CHECK(rdq[1], 16'hC301)
    // x8 read keeps only the low lines
    wide_bus = 1'b0;
    issue(1'b0, nand_host_pkg::OP_READ, 16'h0000);
    `CHECK(rdq.size(), 3)
    `CHECK(rdq[2], 16'h0002)
    `CHECK(pins.chip_sel_n, 1'b1)
  endtask
  initial begin
    repeat (16) @(posedge clk);
    `CHECK(pins.chip_sel_n, 1'b1)
    `CHECK(pins.io_oe, 1'b0)
    #1 rst_n = 1'b1;
    t_pointers();
    t_wide();
    t_program();
    t_protect();
    t_read();
    print_verdict();
  end
endmodule
